// file: rtl/sleep_wake_defs.vh
`ifndef SLEEP_WAKE_DEFS_VH
`define SLEEP_WAKE_DEFS_VH
// apb register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_IRQ_STAT 12'h008
`define OFF_IRQ_MASK 12'h00c
`define OFF_PORT_SNAP 12'h010
`define OFF_WDT_CNT 12'h014
// control field positions
`define CTRL_WDT_EN 0
`define CTRL_WAKE_CHG_EN 1
`define CTRL_MASTER_CLEAR_PIN_EN 2
`define CTRL_OSC_XTAL 3
`define CTRL_RESET 4'h7
// status field positions
`define ST_PD 0
`define ST_TO 1
`define ST_WAKE 2
`define ST_SLEEP 3
`define ST_CORE_RST 4
// interrupt event bits
`define EV_SLEEP 0
`define EV_WAKE_WDT 1
`define EV_WAKE_MASTER_CLEAR_PIN 2
`define EV_WAKE_CHG 3
`define EV_WDT_RST 4
// timing
`define CLK_MHZ 50
`define DRT_RC_US 300
`define DRT_XT_US 18000
`define WDT_PERIOD_US 18000
`endif

// file: rtl/sync_edge.v
`timescale 1ns/10ps
// two-stage synchroniser; output taken from the second stage, no change detect
module sync_edge #(
  parameter W = 1
) (
  clk,
  rst_n,
  ce,
  din,
  dout
);
  input wire clk;
  input wire rst_n;
  input wire ce;
  input wire [W-1:0] din;
  output reg [W-1:0] dout;
  reg [W-1:0] s1_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else if (ce) begin
      s1_q <= din;
      dout <= s1_q;
    end
  end
endmodule

// file: rtl/down_timer.v
`timescale 1ns/10ps
// loadable down-counter; done pulses once when it reaches zero
module down_timer #(
  parameter W = 20
) (
  clk,
  rst_n,
  ce,
  clr,
  load,
  load_val,
  run,
  count,
  done
);
  input wire clk;
  input wire rst_n;
  input wire ce;
  input wire clr;
  input wire load;
  input wire [W-1:0] load_val;
  input wire run;
  output reg [W-1:0] count;
  output reg done;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {W{1'b0}};
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (load || clr) begin
        count <= load_val;
      end else if (run && count != {W{1'b0}}) begin
        count <= count - {{(W-1){1'b0}}, 1'b1};
        if (count == {{(W-1){1'b0}}, 1'b1}) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// file: rtl/sleep_wake_controller.v
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// R01: sleep instruction enters power-down mode
// R02: on sleep: clear watchdog, set TO, clear PD, stop osc
// R03: ports hold their state while asleep
// R04: watchdog reset never drives master clear low
// R05: master clear wakes only when configured for reset
// R06: wake on watchdog or enabled pin change
// R07: every wake is a full device reset
// R08: watchdog wake clears time-out flag
// R09: PD set at power-up, cleared by sleep
// R10: pin change flag set on change in sleep
// R11: compare pins against last read snapshot
// R12: watchdog cleared on every wake
// R13: flag encodings per reset cause
// R14: master clear outside sleep leaves flags unchanged
// R15: watchdog time-out starts device reset timer
// R16: pin change watched only in sleep when enabled
`include "sleep_wake_defs.vh"
module sleep_wake_controller #(
  parameter WDT_CYCLES = `WDT_PERIOD_US * `CLK_MHZ,
  parameter DRT_RC_CYCLES = `DRT_RC_US * `CLK_MHZ,
  parameter DRT_XT_CYCLES = `DRT_XT_US * `CLK_MHZ
) (
  clk,
  rst_n,
  ce,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  irq,
  sleep_exec,
  clrwdt_exec,
  port_access,
  master_clear_pin,
  port_b_bit0,
  port_b_bit1,
  port_b_bit3,
  port_b_bit4,
  port_out_in,
  port_oe_in,
  port_out,
  port_oe,
  core_reset,
  osc_enable,
  master_clear_oe,
  timeout_flag_n,
  powerdown_flag_n,
  pin_change_wake_flag
);
  input wire clk;
  input wire rst_n;
  input wire ce;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  output wire irq;
  input wire sleep_exec;
  input wire clrwdt_exec;
  input wire port_access;
  input wire master_clear_pin;
  input wire port_b_bit0;
  input wire port_b_bit1;
  input wire port_b_bit3;
  input wire port_b_bit4;
  input wire [5:0] port_out_in;
  input wire [5:0] port_oe_in;
  output reg [5:0] port_out;
  output reg [5:0] port_oe;
  output wire core_reset;
  output wire osc_enable;
  output wire master_clear_oe;
  output wire timeout_flag_n;
  output wire powerdown_flag_n;
  output wire pin_change_wake_flag;

  localparam ST_POR = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_SLEEP = 2'd2;
  localparam ST_DRT = 2'd3;

  reg [1:0] state_q;
  reg [3:0] ctrl_q;
  reg to_q;
  reg pd_q;
  reg wake_q;
  reg [3:0] snap_q;
  reg [4:0] irq_stat_q;
  reg [4:0] irq_mask_q;
  reg master_clear_pin_prev_q;
  reg drt_ld;
  reg [4:0] ev;

  wire [3:0] pins_raw;
  wire [3:0] pins_s;
  wire master_clear_pin_s;
  wire [31:0] wdt_cnt;
  wire [31:0] drt_cnt;
  wire wdt_done;
  wire drt_done;
  wire wdt_en = ctrl_q[`CTRL_WDT_EN];
  wire chg_en = ctrl_q[`CTRL_WAKE_CHG_EN];
  wire master_clear_pin_en = ctrl_q[`CTRL_MASTER_CLEAR_PIN_EN];
  wire asleep = (state_q == ST_SLEEP);
  wire master_clear_pin_low = master_clear_pin_en && !master_clear_pin_s;
  wire master_clear_pin_fall = master_clear_pin_low && master_clear_pin_prev_q;
  wire chg_hit = asleep && chg_en && (pins_s != snap_q); // [R16] [R11]
  wire wdt_to = wdt_en && wdt_done;
  wire wr = psel && penable && pwrite;
  wire rd = psel && !pwrite;
  wire [31:0] drt_val;
  reg drt_xt_q;

  assign pins_raw = {port_b_bit4, port_b_bit3, port_b_bit1, port_b_bit0};
  assign drt_val = (state_q == ST_POR || drt_xt_q) ? DRT_XT_CYCLES :
                   DRT_RC_CYCLES; // [R15]

  sync_edge #(.W(5)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .din({master_clear_pin, pins_raw}),
    .dout({master_clear_pin_s, pins_s})
  );

  // watchdog restarts on sleep entry, clrwdt and every wake
  down_timer #(.W(32)) u_wdt (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clr(state_q == ST_DRT || clrwdt_exec || (state_q == ST_RUN &&
         sleep_exec)), // [R02] [R12]
    .load(wdt_en && wdt_cnt == 32'h0 && !wdt_done),
    .load_val(WDT_CYCLES),
    .run(wdt_en && (state_q == ST_RUN || asleep)),
    .count(wdt_cnt),
    .done(wdt_done)
  );

  down_timer #(.W(32)) u_drt (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clr(1'b0),
    .load(drt_ld),
    .load_val(drt_val),
    // a reset pin still held low stalls the reset timer and so stretches the reset
    .run((state_q == ST_DRT && !master_clear_pin_low) || (state_q == ST_POR && master_clear_pin_s)),
    .count(drt_cnt),
    .done(drt_done)
  );

  always @* begin
    drt_ld = 1'b0;
    ev = 5'h00;
    case (state_q)
      ST_RUN: begin
        if (wdt_to) begin
          drt_ld = 1'b1; // [R15]
          ev[`EV_WDT_RST] = 1'b1;
        end else if (sleep_exec) begin
          ev[`EV_SLEEP] = 1'b1; // [R01]
        end else if (master_clear_pin_fall) begin
          drt_ld = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (master_clear_pin_low) begin
          drt_ld = 1'b1; // [R05]
          ev[`EV_WAKE_MASTER_CLEAR_PIN] = 1'b1;
        end else if (wdt_to) begin
          drt_ld = 1'b1; // [R06]
          ev[`EV_WAKE_WDT] = 1'b1;
        end else if (chg_hit) begin
          drt_ld = 1'b1; // [R06]
          ev[`EV_WAKE_CHG] = 1'b1;
        end
      end
      default: begin
        drt_ld = (state_q == ST_POR) && drt_cnt == 32'h0 && !master_clear_pin_s;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_POR;
      to_q <= 1'b1;
      pd_q <= 1'b1; // [R09]
      wake_q <= 1'b0;
      snap_q <= 4'h0;
      master_clear_pin_prev_q <= 1'b0;
      port_out <= 6'h00;
      port_oe <= 6'h00;
      drt_xt_q <= 1'b0;
    end else if (ce) begin
      master_clear_pin_prev_q <= !master_clear_pin_low;
      if (port_access) begin
        snap_q <= pins_s; // [R11]
      end
      if (!asleep) begin
        port_out <= port_out_in;
        port_oe <= port_oe_in; // [R03]
      end
      case (state_q)
        ST_POR: begin
          drt_xt_q <= ctrl_q[`CTRL_OSC_XTAL];
          if (drt_done) begin
            state_q <= ST_RUN;
            to_q <= 1'b1;
            pd_q <= 1'b1; // [R13]
            wake_q <= 1'b0;
          end
        end
        ST_RUN: begin
          if (wdt_to) begin
            to_q <= 1'b0; // [R13]
            wake_q <= 1'b0;
            state_q <= ST_DRT;
          end else if (sleep_exec) begin
            to_q <= 1'b1; // [R02]
            pd_q <= 1'b0; // [R09]
            state_q <= ST_SLEEP;
          end else if (master_clear_pin_fall) begin
            state_q <= ST_DRT; // [R14]
          end
        end
        ST_SLEEP: begin
          if (master_clear_pin_low) begin
            to_q <= 1'b1; // [R13]
            wake_q <= 1'b0;
            state_q <= ST_DRT; // [R07]
          end else if (wdt_to) begin
            to_q <= 1'b0; // [R08]
            wake_q <= 1'b0;
            state_q <= ST_DRT;
          end else if (chg_hit) begin
            to_q <= 1'b1;
            wake_q <= 1'b1; // [R10]
            state_q <= ST_DRT;
          end
        end
        ST_DRT: begin
          if (drt_done && !master_clear_pin_low) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_POR;
        end
      endcase
    end
  end

  assign core_reset = (state_q == ST_POR) || (state_q == ST_DRT); // [R07]
  assign osc_enable = !asleep; // [R02]
  assign master_clear_oe = 1'b0; // [R04]
  assign timeout_flag_n = to_q;
  assign powerdown_flag_n = pd_q;
  assign pin_change_wake_flag = wake_q;

  // apb slave: zero wait states, unmapped reads zero, errors on unmapped
  reg hit;
  always @* begin
    hit = 1'b1;
    case (paddr)
      `OFF_CTRL: prdata = {28'h0, ctrl_q};
      `OFF_STATUS: prdata = {27'h0, core_reset, asleep, wake_q, to_q, pd_q};
      `OFF_IRQ_STAT: prdata = {27'h0, irq_stat_q};
      `OFF_IRQ_MASK: prdata = {27'h0, irq_mask_q};
      `OFF_PORT_SNAP: prdata = {28'h0, snap_q};
      `OFF_WDT_CNT: prdata = wdt_cnt;
      default: begin
        prdata = 32'h0;
        hit = 1'b0;
      end
    endcase
    if (!rd) begin
      prdata = 32'h0;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `CTRL_RESET;
      irq_stat_q <= 5'h00;
      irq_mask_q <= 5'h00;
    end else if (ce) begin
      if (wr && paddr == `OFF_CTRL) begin
        ctrl_q <= pwdata[3:0];
      end
      if (wr && paddr == `OFF_IRQ_MASK) begin
        irq_mask_q <= pwdata[4:0];
      end
      // a new event wins over a write-one clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~((wr && paddr == `OFF_IRQ_STAT) ?
                     pwdata[4:0] : 5'h00)) | ev;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);
endmodule

// file: test/pin_model.sv
`timescale 1ns/10ps
// far side: reset pin with pull-up, four monitored port pins
module pin_model (
  input wire clk,
  output logic master_clear_pin,
  output logic port_b_bit0,
  output logic port_b_bit1,
  output logic port_b_bit3,
  output logic port_b_bit4
);
  initial begin
    master_clear_pin = 1'b1;
    {port_b_bit4, port_b_bit3, port_b_bit1, port_b_bit0} = 4'h0;
  end
  // pin released returns to the pull-up level
  task press(input int n);
    @(posedge clk);
    master_clear_pin <= 1'b0;
    repeat (n) @(posedge clk);
    master_clear_pin <= 1'b1;
  endtask
  task flip(input logic [3:0] m);
    @(posedge clk);
    {port_b_bit4, port_b_bit3, port_b_bit1, port_b_bit0} <=
      {port_b_bit4, port_b_bit3, port_b_bit1, port_b_bit0} ^ m;
  endtask
endmodule

// file: test/sleep_wake_sva.sv
`timescale 1ns/10ps
module sleep_wake_sva #(
  parameter DRT_RC_CYCLES = 20
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire sleep_exec,
  input wire master_clear_pin,
  input wire [5:0] port_out,
  input wire [5:0] port_oe,
  input wire core_reset,
  input wire osc_enable,
  input wire master_clear_oe,
  input wire timeout_flag_n,
  input wire powerdown_flag_n,
  input wire pin_change_wake_flag
);
  logic [15:0] hi_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hi_q <= 16'h0;
    else hi_q <= core_reset ? hi_q + 16'h1 : 16'h0;
  end
  property p_pin_oe;
    !master_clear_oe;
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin driven");
  property p_sleep;
    ce && sleep_exec && osc_enable && !core_reset |=>
      !osc_enable && !powerdown_flag_n && timeout_flag_n;
  endproperty
  a_sleep: assert property (p_sleep) else $error("bad sleep");
  property p_hold;
    !osc_enable && !$past(osc_enable) && !core_reset |->
      $stable(port_out) && $stable(port_oe);
  endproperty
  a_hold: assert property (p_hold) else $error("port moved");
  property p_code;
    !osc_enable && !core_reset ##1 core_reset |-> ##[0:1]
      {pin_change_wake_flag, timeout_flag_n, powerdown_flag_n}
      inside {3'b110, 3'b000, 3'b010};
  endproperty
  a_code: assert property (p_code) else $error("bad code");
  property p_run_pin;
    osc_enable && !core_reset && !master_clear_pin |=>
      $stable({pin_change_wake_flag, timeout_flag_n, powerdown_flag_n});
  endproperty
  a_run_pin: assert property (p_run_pin) else $error("flags moved");
  // one cycle of slack for the timer's load latency
  property p_timer;
    $fell(core_reset) |-> hi_q >= DRT_RC_CYCLES - 1;
  endproperty
  a_timer: assert property (p_timer) else $error("short reset");
  property p_err;
    psel && penable |-> pslverr == (paddr > 12'h014);
  endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no pready");
endmodule
bind sleep_wake_controller sleep_wake_sva #(
  .DRT_RC_CYCLES(DRT_RC_CYCLES)
) u_sva (.*);

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk = 0, rst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic sleep_exec = 0, clrwdt_exec = 0, port_access = 0, perr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [5:0] port_out_in = 0, port_oe_in = 0;
  wire [31:0] prdata;
  wire [5:0] port_out, port_oe;
  wire pready, pslverr, irq, core_reset, osc_enable, master_clear_oe;
  wire timeout_flag_n, powerdown_flag_n, pin_change_wake_flag;
  wire master_clear_pin, port_b_bit0, port_b_bit1, port_b_bit3, port_b_bit4;
  wire [31:0] fl = {29'h0, pin_change_wake_flag, timeout_flag_n,
    powerdown_flag_n};
  int errors = 0, n_checks = 0, i, cyc = 0;
  sleep_wake_controller #(.WDT_CYCLES(50), .DRT_RC_CYCLES(20),
    .DRT_XT_CYCLES(40)) DUT (.*);
  pin_model pm (.*);
  initial forever #10 clk = ~clk;
  // the running core keeps the watchdog quiet; asleep it cannot
  always @(posedge clk) begin
    cyc <= cyc + 1;
    clrwdt_exec <= osc_enable === 1'b1 && core_reset === 1'b0 &&
      cyc[3:0] == 4'h0;
  end
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin errors++; report_and_stop; end
    rd = prdata;
    perr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wcr(input logic v);
    for (i = 0; i < 300 && core_reset !== v; i++) @(posedge clk);
    if (core_reset !== v) begin errors++; report_and_stop; end
  endtask
  task slp;
    @(posedge clk); sleep_exec <= 1'b1;
    @(posedge clk); sleep_exec <= 1'b0;
  endtask
  task snap;
    @(posedge clk); port_access <= 1'b1;
    @(posedge clk); port_access <= 1'b0;
  endtask
  task t_regs;
    apb(0, 12'h000, 0); chk(rd, 32'h7);
    apb(0, 12'h004, 0); chk(rd, 32'h3);
    chk(fl, 32'h3);
    apb(0, 12'h020, 0); chk({perr, rd}, {1'b1, 32'h0});
  endtask
  // clock enable low freezes the counter and ignores a sleep pulse
  task t_freeze;
    logic [31:0] v;
    ce <= 1'b0;
    apb(0, 12'h014, 0); v = rd;
    slp; repeat (3) @(posedge clk);
    chk(osc_enable, 1);
    apb(0, 12'h014, 0); chk(rd, v);
    ce <= 1'b1;
    @(posedge clk);
  endtask
  task t_watchdog;
    apb(1, 12'h00c, 0); snap; slp;
    repeat (2) @(posedge clk); chk(fl, 32'h2);
    chk(irq, 0);
    apb(1, 12'h00c, 1); @(posedge clk); chk(irq, 1);
    apb(1, 12'h008, 1); @(posedge clk); chk(irq, 0);
    wcr(1); wcr(0); chk(fl, 32'h0);
  endtask
  task t_change;
    pm.flip(4'h1); repeat (10) @(posedge clk); chk(core_reset, 0);
    port_out_in <= 6'h2a; port_oe_in <= 6'h0f; snap; slp;
    port_out_in <= 6'h15; port_oe_in <= 6'h30;
    repeat (4) @(posedge clk); chk({port_oe, port_out}, 12'h3ea);
    pm.flip(4'h2); wcr(1); wcr(0); chk(fl, 32'h6);
  endtask
  task t_stale;
    snap; pm.flip(4'h8); slp;
    repeat (8) @(posedge clk); chk(core_reset, 1);
    wcr(0); chk(fl, 32'h6);
  endtask
  task t_pin_reset;
    apb(1, 12'h000, 32'h2); snap; slp; pm.press(4);
    repeat (6) @(posedge clk); chk(core_reset, 0);
    pm.flip(4'h1); wcr(1); wcr(0);
    apb(1, 12'h000, 32'h7); snap; slp; pm.press(4);
    wcr(1); wcr(0); chk(fl, 32'h2);
    pm.press(4); wcr(1); wcr(0); chk(fl, 32'h2);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wcr(0);
    t_regs;
    t_freeze;
    t_watchdog;
    t_change;
    t_stale;
    t_pin_reset;
    report_and_stop;
  end
endmodule
